// ---- src/adsf_map.vh ----
`ifndef ADSF_MAP_VH
`define ADSF_MAP_VH

// Status byte bit positions
`define ADSF_ST_IRQ_SRC    7
`define ADSF_ST_LIN        6
`define ADSF_ST_OV         5
`define ADSF_ST_UV         4
`define ADSF_ST_HEAT       3
`define ADSF_ST_HS_THERM   2
`define ADSF_ST_WAKE2      1
`define ADSF_ST_WAKE1      0

// Control byte bit positions
`define ADSF_CT_HS3_ON     4
`define ADSF_CT_HS2_ON     3
`define ADSF_CT_HS1_ON     2

// Reset values
`define ADSF_CTRL_RST      8'h00
`define ADSF_HS_RST        3'h0

// Transfer length in sample edges
`define ADSF_XFER_BITS     4'h8

// Width of the asynchronous input bundle
`define ADSF_SYNC_W        14

`endif

// ---- src/adsf_sync.v ----
`timescale 1ns/100ps
`include "adsf_map.vh"

// Two-stage synchroniser for the whole bundle of asynchronous inputs
module adsf_sync
(
	input  wire                      clock,
	input  wire                      rstn,
	input  wire [`ADSF_SYNC_W-1:0]   async_in,
	output reg  [`ADSF_SYNC_W-1:0]   sync_out
);

	reg [`ADSF_SYNC_W-1:0] meta_reg;

	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_reg <= {`ADSF_SYNC_W{1'b0}};
			sync_out <= {`ADSF_SYNC_W{1'b0}};
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule // adsf_sync

// ---- src/adsf_status.v ----
`timescale 1ns/100ps
`include "adsf_map.vh"

// Summary of operation
// - The LIN event flag is set by a LIN wake-up or a LIN over-current or over-temperature fault, and is 0 otherwise.
// - A LIN fault disables the LIN transmitter.
// - The LIN transmitter comes back only once the fault is gone and the LIN event flag is cleared.
// - A completed SPI read that returned the LIN event flag as set clears that flag.
// - An over-voltage on supply one sets the over-voltage flag, which is 0 otherwise.
// - An under-voltage on supply one sets the under-voltage flag, which is 0 otherwise.
// - A regulator over-temperature sets the heat warning flag as an early warning, 0 otherwise.
// - The high-side thermal flag is set when a high side overheats and is switched off, 0 otherwise.
// - An over-temperature on any high side switches off every high side.
// - High sides return only after a read clears the thermal flag and a later write sets the enable bit.
// - While the interrupt-source bit is 0 the two wake input bits show the live levels of the two wake pins.
// - While the interrupt-source bit is 1 the wake input bits name the wake pin that caused the wake-up.
// - The status byte holds, from bit 7 down, irq source, LIN event, over-voltage, under-voltage, heat, thermal, wake2, wake1.
// - With the irq source bit at 1 bits 1 to 0 report the wake-up source, at 0 they report the live wake pin levels.
// - The first SPI read after reset returns the battery-fail state on bit 4.
// - The status byte is captured on the falling edge of slave select.
module adsf_status
(
	input  wire        clock,
	input  wire        rstn,
	input  wire        spi_ss_n,
	input  wire        spi_sck,
	input  wire        spi_mosi,
	output reg         spi_miso,
	output reg         spi_miso_oe,
	input  wire        lin_wake_in,
	input  wire        lin_fault_in,
	input  wire        supply_one_ov_in,
	input  wire        supply_one_uv_in,
	input  wire        battery_fail_in,
	input  wire        regulator_heat_in,
	input  wire [2:0]  highside_heat_in,
	input  wire        wake1_pin,
	input  wire        wake2_pin,
	input  wire        low_power_active,
	output reg         lin_tx_enable,
	output reg  [2:0]  highside_on,
	output reg  [7:0]  ctrl_byte,
	output reg         ctrl_strobe
);

	wire [`ADSF_SYNC_W-1:0] sync_bus;

	adsf_sync u_sync
	(
		.clock    (clock),
		.rstn     (rstn),
		.async_in ({spi_ss_n, spi_sck, spi_mosi, lin_wake_in, lin_fault_in,
		            supply_one_ov_in, supply_one_uv_in, battery_fail_in,
		            regulator_heat_in, highside_heat_in, wake1_pin, wake2_pin}),
		.sync_out (sync_bus)
	);

	wire       ss_n_s    = sync_bus[13];
	wire       sck_s     = sync_bus[12];
	wire       mosi_s    = sync_bus[11];
	wire       lin_wake  = sync_bus[10];
	wire       lin_fault = sync_bus[9];
	wire       ov_s      = sync_bus[8];
	wire       uv_s      = sync_bus[7];
	wire       battery_fail_flag_s = sync_bus[6];
	wire       heat_s    = sync_bus[5];
	wire [2:0] hs_heat_s = sync_bus[4:2];
	wire       wake1_s   = sync_bus[1];
	wire       wake2_s   = sync_bus[0];

	// Edge history, taken from synchronised copies only
	reg        ss_n_d_reg;
	reg        sck_d_reg;
	reg        lin_wake_d_reg;
	reg        wake1_d_reg;
	reg        wake2_d_reg;

	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			// Same level as the synchroniser's reset, so no false select follows reset
			ss_n_d_reg     <= 1'b0;
			sck_d_reg      <= 1'b0;
			lin_wake_d_reg <= 1'b0;
			wake1_d_reg    <= 1'b0;
			wake2_d_reg    <= 1'b0;
		end
		else
		begin
			ss_n_d_reg     <= ss_n_s;
			sck_d_reg      <= sck_s;
			lin_wake_d_reg <= lin_wake;
			wake1_d_reg    <= wake1_s;
			wake2_d_reg    <= wake2_s;
		end
	end

	wire ss_fall   = ss_n_d_reg & ~ss_n_s;
	wire ss_rise   = ~ss_n_d_reg & ss_n_s;
	wire sck_rise  = ~ss_n_s & ~sck_d_reg & sck_s;
	wire sck_fall  = ~ss_n_s & sck_d_reg & ~sck_s;
	wire lin_wk_up = lin_wake & ~lin_wake_d_reg;
	wire wk1_up    = wake1_s & ~wake1_d_reg;
	wire wk2_up    = wake2_s & ~wake2_d_reg;

	// Sticky flags
	reg        lin_flag_reg;
	reg        ov_flag_reg;
	reg        uv_flag_reg;
	reg        heat_flag_reg;
	reg        hs_therm_reg;
	reg        irq_src_reg;
	reg  [1:0] wake_src_reg;
	reg        first_read_reg;
	reg        lin_block_reg;

	// SPI shift state
	reg  [7:0] tx_reg;
	reg  [7:0] rx_reg;
	reg  [7:0] sent_reg;
	reg  [3:0] edge_cnt_reg;
	reg        active_reg;

	// Only a transfer of exactly eight sample edges counts
	// A cut frame still ends cleanly: no write, no clears
	wire       xfer_ok = ss_rise & active_reg & (edge_cnt_reg == `ADSF_XFER_BITS);

	// A flag is cleared only when the byte just read showed it set
	function clr_on_read;
		input ok;
		input shown;
		begin
			clr_on_read = ok & shown;
		end
	endfunction

	wire clr_lin  = clr_on_read(xfer_ok, sent_reg[`ADSF_ST_LIN]);
	wire clr_ov   = clr_on_read(xfer_ok, sent_reg[`ADSF_ST_OV]);
	wire clr_uv   = clr_on_read(xfer_ok, sent_reg[`ADSF_ST_UV] & ~first_read_reg);
	wire clr_heat = clr_on_read(xfer_ok, sent_reg[`ADSF_ST_HEAT]);
	wire clr_hs   = clr_on_read(xfer_ok, sent_reg[`ADSF_ST_HS_THERM]);
	wire clr_irq  = clr_on_read(xfer_ok, sent_reg[`ADSF_ST_IRQ_SRC]);

	// Wake edges set the irq source only in low power; in run mode the pins are plain levels
	wire wake_evt = low_power_active & (wk1_up | wk2_up | lin_wk_up);
	wire hs_hot   = |hs_heat_s;

	// Set wins over a clear in the same cycle
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			lin_flag_reg   <= 1'b0;
			ov_flag_reg    <= 1'b0;
			uv_flag_reg    <= 1'b0;
			heat_flag_reg  <= 1'b0;
			hs_therm_reg   <= 1'b0;
			irq_src_reg    <= 1'b0;
			wake_src_reg   <= 2'h0;
			first_read_reg <= 1'b1;
			lin_block_reg  <= 1'b0;
		end
		else
		begin
			lin_flag_reg  <= (lin_flag_reg & ~clr_lin) | lin_wk_up | lin_fault;
			ov_flag_reg   <= (ov_flag_reg & ~clr_ov) | ov_s;
			uv_flag_reg   <= (uv_flag_reg & ~clr_uv) | uv_s;
			heat_flag_reg <= (heat_flag_reg & ~clr_heat) | heat_s;
			hs_therm_reg  <= (hs_therm_reg & ~clr_hs) | hs_hot;
			irq_src_reg   <= (irq_src_reg & ~clr_irq) | wake_evt;
			if (wake_evt)
				wake_src_reg <= (wake_src_reg & {2{~clr_irq}}) | {wk2_up, wk1_up};
			else if (clr_irq)
				wake_src_reg <= 2'h0;
			if (xfer_ok)
				first_read_reg <= 1'b0;
			// Fault blocks the driver until gone and acknowledged
			if (lin_fault)
				lin_block_reg <= 1'b1;
			else if (!lin_flag_reg)
				lin_block_reg <= 1'b0;
		end
	end

	// Status byte as it stands now
	reg  [7:0] status_now;

	always @*
	begin
		status_now                     = 8'h00;
		status_now[`ADSF_ST_IRQ_SRC]   = irq_src_reg;
		status_now[`ADSF_ST_LIN]       = lin_flag_reg;
		status_now[`ADSF_ST_OV]        = ov_flag_reg;
		status_now[`ADSF_ST_UV]        = first_read_reg ? battery_fail_flag_s : uv_flag_reg;
		status_now[`ADSF_ST_HEAT]      = heat_flag_reg;
		status_now[`ADSF_ST_HS_THERM]  = hs_therm_reg;
		if (irq_src_reg)
		begin
			status_now[`ADSF_ST_WAKE2] = wake_src_reg[1];
			status_now[`ADSF_ST_WAKE1] = wake_src_reg[0];
		end
		else
		begin
			status_now[`ADSF_ST_WAKE2] = wake2_s;
			status_now[`ADSF_ST_WAKE1] = wake1_s;
		end
	end

	// SPI slave: master samples on falling edge, we shift on rising edge
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_reg       <= 8'h00;
			rx_reg       <= 8'h00;
			sent_reg     <= 8'h00;
			edge_cnt_reg <= 4'h0;
			active_reg   <= 1'b0;
			spi_miso     <= 1'b0;
			spi_miso_oe  <= 1'b0;
		end
		else if (ss_fall)
		begin
			tx_reg       <= status_now;
			sent_reg     <= status_now;
			spi_miso     <= status_now[7];
			spi_miso_oe  <= 1'b1;
			edge_cnt_reg <= 4'h0;
			active_reg   <= 1'b1;
		end
		else if (ss_n_s)
		begin
			spi_miso_oe  <= 1'b0;
			active_reg   <= 1'b0;
		end
		else
		begin
			if (sck_rise)
			begin
				spi_miso <= tx_reg[7];
				tx_reg   <= {tx_reg[6:0], 1'b0};
			end
			// Saturates so an overlong transfer stays invalid
			if (sck_fall)
			begin
				rx_reg <= {rx_reg[6:0], mosi_s};
				if (edge_cnt_reg != 4'hf)
					edge_cnt_reg <= edge_cnt_reg + 4'h1;
			end
		end
	end

	// Control byte and high-side enables
	reg  [2:0] hs_write;

	always @*
	begin
		hs_write = {rx_reg[`ADSF_CT_HS3_ON], rx_reg[`ADSF_CT_HS2_ON], rx_reg[`ADSF_CT_HS1_ON]};
	end

	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_byte     <= `ADSF_CTRL_RST;
			ctrl_strobe   <= 1'b0;
			highside_on   <= `ADSF_HS_RST;
			lin_tx_enable <= 1'b0;
		end
		else
		begin
			ctrl_strobe   <= xfer_ok;
			lin_tx_enable <= ~lin_block_reg & ~lin_fault;
			if (xfer_ok)
				ctrl_byte <= rx_reg;
			// Overheat kills all sides; enables are refused while the flag stands
			if (hs_hot || hs_therm_reg)
				highside_on <= 3'h0;
			else if (xfer_ok)
				highside_on <= hs_write;
		end
	end

endmodule // adsf_status

// ---- tb/adsf_status_sva.sv ----
`timescale 1ns/100ps
module adsf_status_chk
(
	input logic       clock,
	input logic       rstn,
	input logic       spi_ss_n,
	input logic       spi_sck,
	input logic       spi_miso,
	input logic       spi_miso_oe,
	input logic       lin_fault_in,
	input logic [2:0] highside_heat_in,
	input logic       lin_tx_enable,
	input logic [2:0] highside_on,
	input logic [7:0] ctrl_byte,
	input logic       ctrl_strobe
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// Pins cross two sync stages, hence the slack in each count
	sequence s_sel; $fell(spi_ss_n) ##1 !spi_ss_n [*5]; endsequence
	sequence s_low; (spi_miso_oe && !spi_sck && !spi_ss_n) [*6]; endsequence
	property p_lin_off; lin_fault_in [*5] |-> !lin_tx_enable; endproperty
	property p_lin_back; $rose(lin_tx_enable) |-> !lin_fault_in && !$past(lin_fault_in) && !spi_miso_oe; endproperty
	property p_hs_off; (|highside_heat_in) [*5] |-> highside_on == 3'h0; endproperty
	property p_hs_on; |(highside_on & ~$past(highside_on)) |-> ctrl_strobe; endproperty
	property p_strobe; ctrl_strobe |=> !ctrl_strobe; endproperty
	property p_ctrl; !$stable(ctrl_byte) |-> ctrl_strobe && spi_ss_n; endproperty
	property p_oe_on; s_sel |-> spi_miso_oe; endproperty
	property p_oe_off; spi_ss_n [*6] |-> !spi_miso_oe; endproperty
	property p_hold; s_low |-> $stable(spi_miso); endproperty
	a_lin_off: assert property (p_lin_off) else $error("lin driver on in fault");
	a_lin_back: assert property (p_lin_back) else $error("lin driver back early");
	a_hs_off: assert property (p_hs_off) else $error("high side on while hot");
	a_hs_on: assert property (p_hs_on) else $error("high side on without write");
	a_strobe: assert property (p_strobe) else $error("strobe too long");
	a_ctrl: assert property (p_ctrl) else $error("ctrl change without strobe");
	a_oe_on: assert property (p_oe_on) else $error("miso not driven");
	a_oe_off: assert property (p_oe_off) else $error("miso driven when idle");
	a_hold: assert property (p_hold) else $error("miso moved while sck low");
endmodule // adsf_status_chk

bind adsf_status adsf_status_chk i_chk (.clock(clock), .rstn(rstn), .spi_ss_n(spi_ss_n),
	.spi_sck(spi_sck), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .lin_fault_in(lin_fault_in),
	.highside_heat_in(highside_heat_in), .lin_tx_enable(lin_tx_enable), .highside_on(highside_on),
	.ctrl_byte(ctrl_byte), .ctrl_strobe(ctrl_strobe));

// ---- tb/adsf_spi_master.sv ----
`timescale 1ns/100ps
module adsf_spi_master
(
	input  logic clock,
	input  logic spi_miso,
	output logic spi_ss_n,
	output logic spi_sck,
	output logic spi_mosi
);
	initial
	begin
		spi_ss_n = 1'b1;
		spi_sck = 1'b0;
		spi_mosi = 1'b0;
	end
	task automatic wait_n(input int n);
		repeat (n) @(negedge clock);
	endtask
	// Sck stands low outside frames; n below 8 gives a frame the device must drop
	task automatic xfer(input logic [7:0] wr, input int n, output logic [7:0] rd);
		rd = 8'h00;
		spi_ss_n = 1'b0;
		wait_n(8);
		for (int i = 7; i > 7 - n; i--)
		begin
			spi_mosi = wr[i];
			spi_sck = 1'b1;
			wait_n(4);
			spi_sck = 1'b0;
			wait_n(4);
			rd = {rd[6:0], spi_miso};
		end
		spi_ss_n = 1'b1;
		spi_mosi = ~spi_mosi;
		wait_n(8);
	endtask
endmodule // adsf_spi_master

// ---- tb/tb.sv ----
`timescale 1ns/100ps
module tb;
	logic       clock;
	logic       rstn;
	logic [4:0] cond;
	logic       battery_fail_in;
	logic [2:0] highside_heat_in;
	logic       wake1_pin;
	logic       wake2_pin;
	logic       low_power_active;
	logic [7:0] rd;
	wire        spi_ss_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe, lin_tx_enable;
	wire  [7:0] ctrl_byte;
	wire  [2:0] highside_on;
	int         mismatches;
	int         tests_run;
	int         bitpos [5] = '{6, 6, 5, 4, 3};

	always #25 clock = ~clock;

	adsf_spi_master i_master (.clock(clock), .spi_miso(spi_miso), .spi_ss_n(spi_ss_n),
		.spi_sck(spi_sck), .spi_mosi(spi_mosi));

	adsf_status i_dut (.clock(clock), .rstn(rstn), .spi_ss_n(spi_ss_n), .spi_sck(spi_sck),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .lin_wake_in(cond[0]),
		.lin_fault_in(cond[1]), .supply_one_ov_in(cond[2]), .supply_one_uv_in(cond[3]),
		.battery_fail_in(battery_fail_in), .regulator_heat_in(cond[4]),
		.highside_heat_in(highside_heat_in), .wake1_pin(wake1_pin), .wake2_pin(wake2_pin),
		.low_power_active(low_power_active), .lin_tx_enable(lin_tx_enable),
		.highside_on(highside_on), .ctrl_byte(ctrl_byte), .ctrl_strobe());

	function automatic logic [7:0] live(input logic [7:0] f);
		return f | {6'h00, wake2_pin, wake1_pin};
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic frame(input logic [7:0] wr, input int n, input logic [7:0] exp);
		i_master.xfer(wr, n, rd);
		check(rd, exp);
	endtask

	task automatic end_of_test;
		$display("Comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		#1000000;
		mismatches++;
		end_of_test;
	end

	initial
	begin
		void'($urandom(64));
		{clock, rstn, cond, highside_heat_in, wake1_pin, wake2_pin, low_power_active} = '0;
		battery_fail_in = 1'b1;
		repeat (5) @(negedge clock);
		rstn = 1'b1;
		repeat (6) @(negedge clock);
		check({7'h00, lin_tx_enable}, 8'h01);
		frame(8'h00, 8, live(8'h10));
		frame(8'h00, 8, live(8'h00));
		for (int k = 0; k < 5; k++)
		begin
			{wake2_pin, wake1_pin} = 2'($urandom);
			cond[k] = 1'b1;
			repeat (6 + $urandom_range(12)) @(negedge clock);
			if (k == 1) check({7'h00, lin_tx_enable}, 8'h00);
			cond[k] = 1'b0;
			repeat (6) @(negedge clock);
			if (k == 1) check({7'h00, lin_tx_enable}, 8'h00);
			frame(8'h00, 8, live(8'h01 << bitpos[k]));
			frame(8'h00, 8, live(8'h00));
			if (k == 1) check({7'h00, lin_tx_enable}, 8'h01);
		end
		frame(8'h1c, 8, live(8'h00));
		check(ctrl_byte, 8'h1c);
		check({7'h00, spi_miso_oe}, 8'h00);
		check({5'h00, highside_on}, 8'h07);
		highside_heat_in = 3'h1 << $urandom_range(2);
		repeat (8) @(negedge clock);
		check({5'h00, highside_on}, 8'h00);
		highside_heat_in = 3'h0;
		i_master.xfer(8'h1c, 7, rd);
		check(rd, live(8'h04) >> 1);
		frame(8'h1c, 8, live(8'h04));
		check({5'h00, highside_on}, 8'h00);
		frame(8'h1c, 8, live(8'h00));
		check({5'h00, highside_on}, 8'h07);
		low_power_active = 1'b1;
		{wake2_pin, wake1_pin} = 2'b00;
		repeat (6) @(negedge clock);
		wake1_pin = 1'b1;
		repeat (6) @(negedge clock);
		low_power_active = 1'b0;
		{wake2_pin, wake1_pin} = 2'b10;
		repeat (6) @(negedge clock);
		frame(8'h00, 8, 8'h81);
		frame(8'h00, 8, live(8'h00));
		end_of_test;
	end
endmodule // tb
